// File: rtl/gsdc_pkg.sv
// constants, field layouts and carrier types of the gated six-decade counter
package gsdc_pkg;

  // counting register shape
  localparam int unsigned DIGITS = 6;
  localparam int unsigned BCD_W = 4;
  localparam int unsigned COUNT_W = DIGITS * BCD_W;
  localparam int unsigned SEG_W = 7;
  localparam int unsigned SEGS_W = DIGITS * SEG_W;
  localparam logic [BCD_W-1:0] BCD_ZERO = 4'h0;
  localparam logic [BCD_W-1:0] BCD_ONE = 4'h1;
  localparam logic [BCD_W-1:0] BCD_MAX = 4'h9;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 24'h999999;
  localparam logic [SEG_W-1:0] SEG_ALL = 7'h7f;

  // overflow output pulse: figure in ns, count derived from the clock period
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned OFLOW_PULSE_NS = 2000;
  localparam int unsigned OFLOW_CYC = (OFLOW_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                      OFLOW_PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned PCNT_W = 6;
  localparam logic [PCNT_W-1:0] PCNT_LOAD = PCNT_W'(OFLOW_CYC - 1);
  localparam logic [PCNT_W-1:0] PCNT_ONE = 6'h01;

  // register bus
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_COUNT = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control word fields
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_TEST = 1;
  localparam int unsigned CTRL_RESET = 2;
  localparam int unsigned CTRL_ROLE = 3;
  localparam int unsigned ROLE_W = 2;
  // status word fields
  localparam int unsigned STAT_GATE = 0;
  localparam int unsigned STAT_OVF = 1;

  // system role of the module in a chain
  typedef enum logic [ROLE_W-1:0] {
    ROLE_NORM = 2'h0,
    ROLE_MASTER = 2'h1,
    ROLE_SLAVE = 2'h2
  } gsdc_role_t;

  typedef struct packed {
    gsdc_role_t role;
    logic dispTest;
    logic run;
  } gsdc_ctrl_t;

  localparam gsdc_ctrl_t CTRL_RESET_VAL = '{role: ROLE_NORM, dispTest: 1'b0, run: 1'b0};

  // pin inputs that cross into the clock domain
  typedef struct packed {
    logic count;
    logic extGate;
    logic extReset;
    logic sysGate;
    logic sysReset;
    logic sysPreset;
  } gsdc_pins_t;

  // idle levels: gate open, no reset, shared lines released (pulled high)
  localparam gsdc_pins_t PINS_IDLE = '{count: 1'b0, extGate: 1'b1, extReset: 1'b0,
                                       sysGate: 1'b1, sysReset: 1'b1, sysPreset: 1'b1};

endpackage : gsdc_pkg

// File: rtl/gsdc_counter.sv
// gated six-decade event counter with display drive, system role and register slave
`timescale 1ns/10ps

module gsdc_counter (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic countIn,
  input wire logic extGate,
  input wire logic extReset,
  input wire logic sysGateIn,
  output logic sysGateOut,
  output logic sysGateOen,
  input wire logic sysResetIn,
  output logic sysResetOut,
  output logic sysResetOen,
  input wire logic sysPresetIn,
  output logic [gsdc_pkg::SEGS_W-1:0] segments,
  output logic gateLed,
  output logic overflowLed,
  output logic overflowPulse,
  input wire logic [gsdc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [gsdc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gsdc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [gsdc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import gsdc_pkg::*;

  // word-aligned address hits one of the three registers
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_COUNT);
  endfunction : isMapped

  // one added to a six-digit bcd value, carry out on top
  function automatic logic [COUNT_W:0] bcdInc(input logic [COUNT_W-1:0] v);
    logic [COUNT_W-1:0] r;
    logic carry;
    r = v;
    carry = 1'b1;
    for (int i = 0; i < DIGITS; i++) begin
      if (carry) begin
        if (v[i*BCD_W +: BCD_W] == BCD_MAX) begin
          r[i*BCD_W +: BCD_W] = BCD_ZERO;
        end else begin
          r[i*BCD_W +: BCD_W] = v[i*BCD_W +: BCD_W] + BCD_ONE;
          carry = 1'b0;
        end
      end
    end
    return {carry, r};
  endfunction : bcdInc

  // segment pattern gfedcba, active high
  function automatic logic [SEG_W-1:0] segDecode(input logic [BCD_W-1:0] d);
    case (d)
      4'h0: return 7'h3f;
      4'h1: return 7'h06;
      4'h2: return 7'h5b;
      4'h3: return 7'h4f;
      4'h4: return 7'h66;
      4'h5: return 7'h6d;
      4'h6: return 7'h7d;
      4'h7: return 7'h07;
      4'h8: return 7'h7f;
      4'h9: return 7'h6f;
      default: return 7'h00;
    endcase
  endfunction : segDecode

  gsdc_pins_t pinRaw;
  gsdc_pins_t syncA;
  gsdc_pins_t syncB;
  logic countPrev;
  logic countEvent;
  gsdc_ctrl_t ctrl;
  logic manualReset;
  logic isMaster;
  logic isSlave;
  logic localResetReq;
  logic anyReset;
  logic gateOpen;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W:0] incResult;
  logic wrapEvent;
  logic [PCNT_W-1:0] pulseCnt;
  logic [SEGS_W-1:0] next_segments;
  logic wrFire;
  logic rdFire;
  logic [DATA_W-1:0] readWord;
  logic [6:0] highRun;

  assign pinRaw = '{count: countIn, extGate: extGate, extReset: extReset,
                    sysGate: sysGateIn, sysReset: sysResetIn, sysPreset: sysPresetIn};

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      syncA <= PINS_IDLE;
      syncB <= PINS_IDLE;
    end else if (ce) begin
      syncA <= pinRaw;
      syncB <= syncA;
    end
  end

  // edge detect reads only the second stage
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      countPrev <= 1'b0;
    end else if (ce) begin
      countPrev <= syncB.count;
    end
  end

  // one event per rising edge; pulses narrower than one clock may be lost
  assign countEvent = syncB.count & ~countPrev;

  // role decode; the unused code 3 behaves as normal
  assign isMaster = (ctrl.role == ROLE_MASTER);
  assign isSlave = (ctrl.role == ROLE_SLAVE);

  // reset sources; local ones act in every role
  assign localResetReq = manualReset | syncB.extReset;
  // only a slave listens to the shared reset line (active low)
  assign anyReset = localResetReq | (isSlave & ~syncB.sysReset);

  // combined gate; preset (active low) closes it in every role
  assign gateOpen = ctrl.run & syncB.extGate & syncB.sysPreset & (~isSlave | syncB.sysGate);

  assign incResult = bcdInc(count);
  // wrap seen when a gated event meets 999999
  assign wrapEvent = ce & ~anyReset & gateOpen & countEvent & incResult[COUNT_W];

  // decade counter; reset wins, nothing counts in that cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (ce) begin
      if (anyReset) begin
        count <= '0;
      end else if (gateOpen && countEvent) begin
        count <= incResult[COUNT_W-1:0];
      end
    end
  end

  // sticky overflow, cleared only by a reset source
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      overflowLed <= 1'b0;
    end else if (ce) begin
      if (wrapEvent) begin
        overflowLed <= 1'b1;
      end else if (anyReset) begin
        overflowLed <= 1'b0;
      end
    end
  end

  // timed pulse on every wrap; a wrap inside a pulse restarts it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pulseCnt <= '0;
      overflowPulse <= 1'b0;
    end else if (ce) begin
      if (wrapEvent) begin
        pulseCnt <= PCNT_LOAD;
        overflowPulse <= 1'b1;
      end else if (anyReset) begin
        pulseCnt <= '0;
        overflowPulse <= 1'b0;
      end else if (pulseCnt != '0) begin
        pulseCnt <= pulseCnt - PCNT_ONE;
      end else begin
        overflowPulse <= 1'b0;
      end
    end
  end

  // gate indicator follows the combined gate masked by any reset source
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gateLed <= 1'b0;
    end else if (ce) begin
      gateLed <= gateOpen & ~anyReset;
    end
  end

  // open-drain shared lines: master pulls low, others release
  assign sysGateOut = 1'b0;
  assign sysResetOut = 1'b0;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sysGateOen <= 1'b1;
      sysResetOen <= 1'b1;
    end else if (ce) begin
      sysGateOen <= ~(isMaster & ~gateOpen);
      sysResetOen <= ~(isMaster & localResetReq);
    end
  end

  // display drive: blank leading zeros, test overrides everything
  always_comb begin
    logic leading;
    logic [BCD_W-1:0] digit;
    leading = 1'b1;
    digit = BCD_ZERO;
    next_segments = '0;
    for (int i = DIGITS - 1; i >= 0; i--) begin
      digit = count[i*BCD_W +: BCD_W];
      if (digit != BCD_ZERO || i == 0) begin
        leading = 1'b0;
      end
      if (ctrl.dispTest) begin
        next_segments[i*SEG_W +: SEG_W] = SEG_ALL;
      end else if (!leading) begin
        next_segments[i*SEG_W +: SEG_W] = segDecode(digit);
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      segments <= '0;
    end else if (ce) begin
      segments <= next_segments;
    end
  end

  // write path: address and data are taken together, one response at a time
  assign wrFire = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wrFire;
  assign s_axi_wready = wrFire;

  // control register; the reset bit is a self-clearing strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl <= CTRL_RESET_VAL;
      manualReset <= 1'b0;
    end else if (ce) begin
      manualReset <= 1'b0;
      if (wrFire && s_axi_awaddr == REG_CTRL && s_axi_wstrb[0]) begin
        ctrl.run <= s_axi_wdata[CTRL_RUN];
        ctrl.dispTest <= s_axi_wdata[CTRL_TEST];
        ctrl.role <= gsdc_role_t'(s_axi_wdata[CTRL_ROLE +: ROLE_W]);
        manualReset <= s_axi_wdata[CTRL_RESET];
      end
    end
  end

  // write response; writes to read-only words are dropped with okay
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read path
  assign s_axi_arready = ce & ~s_axi_rvalid;
  assign rdFire = s_axi_arready & s_axi_arvalid;

  always_comb begin
    readWord = '0;
    case (s_axi_araddr)
      REG_CTRL: begin
        readWord[CTRL_RUN] = ctrl.run;
        readWord[CTRL_TEST] = ctrl.dispTest;
        readWord[CTRL_ROLE +: ROLE_W] = ctrl.role;
      end
      REG_STATUS: begin
        readWord[STAT_GATE] = gateLed;
        readWord[STAT_OVF] = overflowLed;
      end
      REG_COUNT: readWord[COUNT_W-1:0] = count;
      default: readWord = '0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readWord;
        s_axi_rresp <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // run length of the overflow pulse, for the check below only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      highRun <= '0;
    end else if (ce) begin
      if (wrapEvent) begin
        highRun <= 7'h01;
      end else if (overflowPulse && highRun != 7'h7f) begin
        highRun <= highRun + 7'h01;
      end
    end
  end

  AST_BCD_RANGE: assert property (@(posedge clock) disable iff (!resetn)
    count[23:20] <= BCD_MAX && count[19:16] <= BCD_MAX && count[15:12] <= BCD_MAX &&
    count[11:8] <= BCD_MAX && count[7:4] <= BCD_MAX && count[3:0] <= BCD_MAX)
    else $error("count digit out of decimal range");

  AST_WRAP_ZERO: assert property (@(posedge clock) disable iff (!resetn)
    wrapEvent |=> count == '0 && overflowLed)
    else $error("wrap did not return count to zero");

  AST_OVF_STICKY: assert property (@(posedge clock) disable iff (!resetn)
    overflowLed && !(ce && anyReset) |=> overflowLed)
    else $error("overflow flag dropped without reset");

  AST_PULSE_LEN: assert property (@(posedge clock) disable iff (!resetn)
    $fell(overflowPulse) && !$past(anyReset) |-> $past(highRun) == OFLOW_CYC)
    else $error("overflow pulse length wrong");

  AST_RESET_CLEARS: assert property (@(posedge clock) disable iff (!resetn)
    ce && anyReset |=> count == '0 && !overflowLed && !overflowPulse ##1 ce |=> segments[6:0] == 7'h3f || segments == '1)
    else $error("reset did not clear count and display");

  AST_GATE_IND: assert property (@(posedge clock) disable iff (!resetn)
    ce |=> gateLed == $past(gateOpen && !anyReset))
    else $error("gate indicator disagrees with gate");

  AST_DISP_TEST: assert property (@(posedge clock) disable iff (!resetn)
    ce && ctrl.dispTest |=> segments == '1)
    else $error("display test did not light all segments");

  AST_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    ce && !anyReset && !(gateOpen && countEvent) |=> $stable(count))
    else $error("count moved while gate closed");

  AST_NORM_NODRIVE: assert property (@(posedge clock) disable iff (!resetn)
    ce && !isMaster ##1 ce |-> sysGateOen && sysResetOen)
    else $error("non-master drove a shared line");

  AST_MASTER_RESET: assert property (@(posedge clock) disable iff (!resetn)
    ce && isMaster && localResetReq |=> !sysResetOen)
    else $error("master did not drive shared reset");

  AST_SLAVE_FOLLOW: assert property (@(posedge clock) disable iff (!resetn)
    ce && isSlave && !syncB.sysReset |=> count == '0)
    else $error("slave ignored shared reset line");

endmodule : gsdc_counter

// File: testbench/gsdc_chain_model.sv
// behavioural chain of peer counting modules on the shared open-drain lines
`timescale 1ns/10ps
module gsdc_chain_model #(
  parameter int PEERS = 3
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic gateOen,
  input wire logic resetOen,
  input wire logic peerGateLow,
  input wire logic peerResetLow,
  input wire logic peerPresetLow,
  output logic sysGate,
  output logic sysReset,
  output logic sysPreset,
  output logic [7:0] resetsSeen
);
  logic lastReset;

  initial begin
    if (PEERS + 1 > 50) begin
      $display("wrong value at %0t: %h vs %h", $time, PEERS + 1, 50);
    end
  end

  // wired-and lines, pulled high when nobody sinks them
  assign sysGate = gateOen & !peerGateLow;
  assign sysReset = resetOen & !peerResetLow;
  assign sysPreset = !peerPresetLow;

  // counts reset pulses seen on the shared line, even one-cycle ones
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lastReset <= 1'h1;
      resetsSeen <= 8'h00;
    end else begin
      lastReset <= sysReset;
      if (lastReset && !sysReset) begin
        resetsSeen <= resetsSeen + 8'h01;
      end
    end
  end
endmodule : gsdc_chain_model

// File: testbench/gsdc_counter_bench.sv
// register-level tests of the counter with a chain of peers on the shared lines
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module gsdc_counter_bench;
  import gsdc_pkg::*;
  logic clock = 1'h0;
  logic resetn = 1'h0;
  logic countIn = 1'h0, extGate = 1'h1, extReset = 1'h0;
  logic pGate = 1'h0, pReset = 1'h0, pPreset = 1'h0;
  logic sGate, sReset, sPreset, gOut, gOen, rOut, rOen, gateLed, ovfLed, ovfPulse;
  logic [SEGS_W-1:0] segments;
  logic [7:0] resetsSeen;
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata, rv;
  logic [1:0] bresp, rresp, rr;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  int n_errors = 0;
  int tests_run = 0;

  always #25 clock = ~clock;

  gsdc_counter dut (.clock(clock), .resetn(resetn), .ce(1'h1), .countIn(countIn),
    .extGate(extGate), .extReset(extReset), .sysGateIn(sGate), .sysGateOut(gOut),
    .sysGateOen(gOen), .sysResetIn(sReset), .sysResetOut(rOut), .sysResetOen(rOen),
    .sysPresetIn(sPreset), .segments(segments), .gateLed(gateLed), .overflowLed(ovfLed),
    .overflowPulse(ovfPulse), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  gsdc_chain_model #(.PEERS(3)) chain (.clock(clock), .resetn(resetn), .gateOen(gOen),
    .resetOen(rOen), .peerGateLow(pGate), .peerResetLow(pReset), .peerPresetLow(pPreset),
    .sysGate(sGate), .sysReset(sReset), .sysPreset(sPreset), .resetsSeen(resetsSeen));

  // prints the verdict and stops the run
  task automatic wrap_up();
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // one write; each channel is released at the edge it is taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bready && bvalid));
    bready <= 1'h0;
    @(posedge clock);
  endtask : wr

  // one read; data and response taken at the rvalid edge
  task automatic rd(input logic [ADDR_W-1:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rready && rvalid));
    rv = rdata;
    rr = rresp;
    rready <= 1'h0;
    @(posedge clock);
  endtask : rd

  // events held high and low three clocks each, then the pipeline settles
  task automatic pulse(input int n);
    repeat (n) begin
      countIn <= 1'h1;
      repeat (3) @(posedge clock);
      countIn <= 1'h0;
      repeat (3) @(posedge clock);
    end
    repeat (4) @(posedge clock);
  endtask : pulse

  task automatic pause();
    repeat (5) @(posedge clock);
  endtask : pause

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'h1;
    @(posedge clock);
    rd(REG_CTRL);
    `CHK(rv, 32'h0)
    rd(REG_STATUS);
    `CHK(rv, 32'h0)
    rd(8'h0c);
    `CHK(rr, RESP_SLVERR)
    wr(REG_CTRL, 32'h1);
    rd(REG_STATUS);
    `CHK(rv, 32'h1)
    pulse(5);
    rd(REG_COUNT);
    `CHK(rv, 32'h5)
    `CHK(segments, 42'h6d)
    wr(REG_CTRL, 32'h3);
    pause();
    `CHK(segments, {6{SEG_ALL}})
    wr(REG_CTRL, 32'h1);
    // gate closed from the pin: events are lost, count holds
    extGate <= 1'h0;
    pause();
    `CHK(gateLed, 1'h0)
    pulse(2);
    rd(REG_COUNT);
    `CHK(rv, 32'h5)
    extGate <= 1'h1;
    pPreset <= 1'h1;
    pause();
    `CHK(gateLed, 1'h0)
    pPreset <= 1'h0;
    pause();
    `CHK(gateLed, 1'h1)
    wr(REG_CTRL, 32'h5);
    rd(REG_COUNT);
    `CHK(rv, 32'h0)
    pulse(3);
    extReset <= 1'h1;
    pause();
    extReset <= 1'h0;
    rd(REG_COUNT);
    `CHK(rv, 32'h0)
    pulse(3);
    // normal role ignores the shared lines and never drives them
    pReset <= 1'h1;
    pGate <= 1'h1;
    pause();
    `CHK(gateLed, 1'h1)
    pReset <= 1'h0;
    pGate <= 1'h0;
    rd(REG_COUNT);
    `CHK(rv, 32'h3)
    wr(REG_CTRL, 32'h0);
    pause();
    `CHK(gOen, 1'h1)
    `CHK(resetsSeen, 8'h01)
    wr(REG_CTRL, 32'h8);
    pause();
    `CHK(gOen, 1'h0)
    wr(REG_CTRL, 32'hc);
    pause();
    `CHK(resetsSeen, 8'h02)
    wr(REG_CTRL, 32'h11);
    rd(REG_CTRL);
    `CHK(rv, 32'h11)
    pGate <= 1'h1;
    pause();
    `CHK(gateLed, 1'h0)
    pGate <= 1'h0;
    pulse(2);
    rd(REG_COUNT);
    `CHK(rv, 32'h2)
    pReset <= 1'h1;
    pause();
    pReset <= 1'h0;
    rd(REG_COUNT);
    `CHK(rv, 32'h0)
    `CHK(ovfLed, 1'h0)
    wrap_up();
  end
endmodule : gsdc_counter_bench
